// ===== logic/aie_alu.sv
`default_nettype none
module aie_alu (
    // operation and operands
    input wire aie_pkg::aie_op_type op_in,
    input wire logic [7:0] w_in,
    input wire logic [7:0] opnd_in,
    input wire aie_pkg::aie_flags_type flags_in,
    // result and new flags
    output logic [7:0] result_out,
    output var aie_pkg::aie_flags_type flags_out
);
    logic [4:0] low_sum;
    logic [8:0] sum9;
    logic cin;

    // carry in only for the carry form of the add
    always_comb begin
        cin = (op_in == aie_pkg::OP_ADD_CARRY_REG) ? flags_in.c : 1'b0;
        low_sum = {1'b0, w_in[3:0]} + {1'b0, opnd_in[3:0]} + {4'h0, cin};
        sum9 = {1'b0, w_in} + {1'b0, opnd_in} + {8'h00, cin};
        flags_out = flags_in;
        result_out = 8'h00;
        case (op_in)
            aie_pkg::OP_ADD_LIT, aie_pkg::OP_ADD_REG, aie_pkg::OP_ADD_CARRY_REG: begin
                result_out = sum9[7:0];
                // all five flags follow an add
                flags_out.c = sum9[8];
                flags_out.digit_carry_flag = low_sum[4];
                flags_out.overflow_flag = (w_in[7] == opnd_in[7]) && (sum9[7] != w_in[7]);
                flags_out.z = (sum9[7:0] == 8'h00);
                flags_out.n = sum9[7];
            end
            aie_pkg::OP_AND_LIT: begin
                result_out = w_in & opnd_in;
                // only zero and negative move, the rest are kept
                flags_out.z = ((w_in & opnd_in) == 8'h00);
                flags_out.n = w_in[7] & opnd_in[7];
            end
            default: begin
                result_out = 8'h00;
            end
        endcase
    end
endmodule // aie_alu
`default_nettype wire

// ===== logic/aie_exec.sv
`default_nettype none
module aie_exec (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // instruction hand-in
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_in,
    output logic instr_ready_out,
    // core state used for addressing
    input wire logic ext_set_en_in,
    input wire logic [3:0] bank_select_register_in,
    input wire logic [11:0] index_base_in,
    // data memory
    input wire logic [7:0] mem_rd_data_in,
    output var aie_pkg::aie_mem_req_type mem_req_out,
    // architectural state
    output logic [7:0] w_out,
    output var aie_pkg::aie_flags_type flags_out,
    output logic done_out
);
    aie_pkg::aie_phase_type st_q, st_d;
    aie_pkg::aie_op_type op_q, op_d;
    aie_pkg::aie_flags_type flags_q, flags_d, alu_flags;
    logic [15:0] instr_q, instr_d;
    logic [11:0] addr_q, addr_d;
    logic [7:0] opnd_q, opnd_d, res_q, res_d, w_q, w_d, alu_res;
    logic wr_en_q, wr_en_d, done_q, done_d, ready_q, ready_d;
    logic to_w;
    logic [8:0] exp_sum9;

    // opcode decode, shared by the datapath and its checks
    function automatic aie_pkg::aie_op_type decode_op(input logic [15:0] ins);
        aie_pkg::aie_op_type op;
        op = aie_pkg::OP_NONE;
        if (ins[15:8] == aie_pkg::OPC_ADD_LIT) begin
            op = aie_pkg::OP_ADD_LIT;
        end else if (ins[15:8] == aie_pkg::OPC_AND_LIT) begin
            op = aie_pkg::OP_AND_LIT;
        end else if (ins[15:10] == aie_pkg::OPC_ADD_REG) begin
            op = aie_pkg::OP_ADD_REG;
        end else if (ins[15:10] == aie_pkg::OPC_ADD_CARRY_REG) begin
            op = aie_pkg::OP_ADD_CARRY_REG;
        end
        return op;
    endfunction

    function automatic logic is_file_op(input aie_pkg::aie_op_type op);
        return (op == aie_pkg::OP_ADD_REG) || (op == aie_pkg::OP_ADD_CARRY_REG);
    endfunction

    // file address resolution; bank select and index base sampled in decode
    function automatic logic [11:0] resolve_addr(input logic [7:0] f, input logic acc,
        input logic ext, input logic [3:0] bank, input logic [11:0] base);
        logic [11:0] a;
        a = {bank, f};
        if (!acc) begin
            if (ext && (f <= aie_pkg::INDEX_LIMIT)) begin
                a = base + {4'h0, f};
            end else if (f < aie_pkg::ACCESS_SPLIT) begin
                a = {aie_pkg::ACCESS_LOW_BANK, f};
            end else begin
                a = {aie_pkg::ACCESS_HIGH_BANK, f};
            end
        end
        return a;
    endfunction

    aie_alu u_alu (
        .op_in(op_q),
        .w_in(w_q),
        .opnd_in(opnd_q),
        .flags_in(flags_q),
        .result_out(alu_res),
        .flags_out(alu_flags)
    );

    // literals and destination 0 go to the working register
    assign to_w = !is_file_op(op_q) || !instr_q[aie_pkg::DEST_BIT];

    // phase sequencer and datapath next values
    always_comb begin
        st_d = st_q;
        op_d = op_q;
        instr_d = instr_q;
        addr_d = addr_q;
        opnd_d = opnd_q;
        res_d = res_q;
        w_d = w_q;
        flags_d = flags_q;
        wr_en_d = 1'b0;
        done_d = 1'b0;
        case (st_q)
            aie_pkg::PH_IDLE, aie_pkg::PH_WRITE: begin
                // a new word may enter while the previous one writes
                if (instr_valid_in && ready_q) begin
                    instr_d = instr_in;
                    st_d = aie_pkg::PH_DECODE;
                end else begin
                    st_d = aie_pkg::PH_IDLE;
                end
            end
            aie_pkg::PH_DECODE: begin
                op_d = decode_op(instr_q);
                addr_d = resolve_addr(instr_q[7:0], instr_q[aie_pkg::ACCESS_BIT],
                    ext_set_en_in, bank_select_register_in, index_base_in);
                st_d = aie_pkg::PH_READ;
            end
            aie_pkg::PH_READ: begin
                // memory answers combinationally to the registered address
                opnd_d = is_file_op(op_q) ? mem_rd_data_in : instr_q[7:0];
                st_d = aie_pkg::PH_PROC;
            end
            aie_pkg::PH_PROC: begin
                // result commits at the end of processing, shows in write phase
                if (op_q != aie_pkg::OP_NONE) begin
                    flags_d = alu_flags;
                    res_d = alu_res;
                    if (to_w) begin
                        w_d = alu_res;
                    end else begin
                        wr_en_d = 1'b1;
                    end
                end
                done_d = 1'b1;
                st_d = aie_pkg::PH_WRITE;
            end
            default: begin
                st_d = aie_pkg::PH_IDLE;
            end
        endcase
        ready_d = (st_d == aie_pkg::PH_IDLE) || (st_d == aie_pkg::PH_WRITE);
    end

    // state registers
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= aie_pkg::PH_IDLE;
            op_q <= aie_pkg::OP_NONE;
            instr_q <= aie_pkg::INSTR_RESET;
            addr_q <= 12'h000;
            opnd_q <= 8'h00;
            res_q <= 8'h00;
            w_q <= aie_pkg::W_RESET;
            flags_q <= aie_pkg::FLAGS_RESET;
            wr_en_q <= 1'b0;
            done_q <= 1'b0;
            ready_q <= 1'b1;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            instr_q <= instr_d;
            addr_q <= addr_d;
            opnd_q <= opnd_d;
            res_q <= res_d;
            w_q <= w_d;
            flags_q <= flags_d;
            wr_en_q <= wr_en_d;
            done_q <= done_d;
            ready_q <= ready_d;
        end
    end

    assign instr_ready_out = ready_q;
    assign mem_req_out = '{addr: addr_q, wr_en: wr_en_q, wr_data: res_q};
    assign w_out = w_q;
    assign flags_out = flags_q;
    assign done_out = done_q;

    // independent sum model for the checks below
    assign exp_sum9 = {1'b0, w_q} + {1'b0, opnd_q}
        + {8'h00, (op_q == aie_pkg::OP_ADD_CARRY_REG) & flags_q.c};

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_add_lit;
        (st_q == aie_pkg::PH_PROC && op_q == aie_pkg::OP_ADD_LIT)
            |=> (w_q == $past(exp_sum9[7:0])) && !wr_en_q;
    endproperty
    a_add_lit: assert property (p_add_lit) else $error("add literal result wrong");

    property p_add_reg;
        (st_q == aie_pkg::PH_PROC && op_q == aie_pkg::OP_ADD_REG)
            |=> (res_q == $past(exp_sum9[7:0]));
    endproperty
    a_add_reg: assert property (p_add_reg) else $error("add register sum wrong");

    property p_dest_w;
        (st_q == aie_pkg::PH_PROC && is_file_op(op_q) && !instr_q[aie_pkg::DEST_BIT])
            |=> !wr_en_q && (w_q == res_q);
    endproperty
    a_dest_w: assert property (p_dest_w) else $error("destination 0 misrouted");

    property p_dest_f;
        (st_q == aie_pkg::PH_PROC && is_file_op(op_q) && instr_q[aie_pkg::DEST_BIT])
            |=> wr_en_q && (w_q == $past(w_q)) ##1 !wr_en_q;
    endproperty
    a_dest_f: assert property (p_dest_f) else $error("destination 1 misrouted");

    property p_access_bank;
        (st_q == aie_pkg::PH_DECODE && !instr_q[aie_pkg::ACCESS_BIT]
            && !(ext_set_en_in && instr_q[7:0] <= aie_pkg::INDEX_LIMIT))
            |=> (addr_q[11:8] == ((instr_q[7] || instr_q[6:5] == 2'b11) ? 4'hF : 4'h0));
    endproperty
    a_access_bank: assert property (p_access_bank) else $error("access bank wrong");

    property p_bsr_bank;
        (st_q == aie_pkg::PH_DECODE && instr_q[aie_pkg::ACCESS_BIT])
            |=> (addr_q == {$past(bank_select_register_in), instr_q[7:0]});
    endproperty
    a_bsr_bank: assert property (p_bsr_bank) else $error("bank select not used");

    property p_indexed;
        (st_q == aie_pkg::PH_DECODE && !instr_q[aie_pkg::ACCESS_BIT] && ext_set_en_in
            && instr_q[7:0] <= aie_pkg::INDEX_LIMIT)
            |=> (addr_q == $past(index_base_in) + {4'h0, instr_q[7:0]});
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed offset wrong");

    property p_carry_sum;
        (st_q == aie_pkg::PH_PROC && op_q == aie_pkg::OP_ADD_CARRY_REG)
            |=> (res_q == $past(w_q) + $past(opnd_q) + {7'h00, $past(flags_q.c)});
    endproperty
    a_carry_sum: assert property (p_carry_sum) else $error("carry add sum wrong");

    property p_carry_route;
        (st_q == aie_pkg::PH_PROC && op_q == aie_pkg::OP_ADD_CARRY_REG)
            |=> (wr_en_q == instr_q[aie_pkg::DEST_BIT]);
    endproperty
    a_carry_route: assert property (p_carry_route) else $error("carry add misrouted");

    property p_add_flags;
        (st_q == aie_pkg::PH_PROC && op_q != aie_pkg::OP_NONE && op_q != aie_pkg::OP_AND_LIT)
            |=> (flags_q.c == $past(exp_sum9[8])) && (flags_q.z == (res_q == 8'h00))
            && (flags_q.n == res_q[7]);
    endproperty
    a_add_flags: assert property (p_add_flags) else $error("add flags wrong");

    property p_and_lit;
        (st_q == aie_pkg::PH_PROC && op_q == aie_pkg::OP_AND_LIT)
            |=> (w_q == ($past(w_q) & $past(opnd_q)));
    endproperty
    a_and_lit: assert property (p_and_lit) else $error("and literal wrong");

    property p_phases;
        (st_q == aie_pkg::PH_DECODE) |=> (st_q == aie_pkg::PH_READ)
            ##1 (st_q == aie_pkg::PH_PROC) ##1 (st_q == aie_pkg::PH_WRITE && done_q);
    endproperty
    a_phases: assert property (p_phases) else $error("phase order broken");

    property p_and_flags;
        (st_q == aie_pkg::PH_PROC && op_q == aie_pkg::OP_AND_LIT)
            |=> (flags_q.c == $past(flags_q.c)) && (flags_q.overflow_flag
            == $past(flags_q.overflow_flag)) && (flags_q.digit_carry_flag
            == $past(flags_q.digit_carry_flag)) && (flags_q.z == (w_q == 8'h00));
    endproperty
    a_and_flags: assert property (p_and_flags) else $error("and flags wrong");
endmodule // aie_exec
`default_nettype wire

// ===== logic/aie_pkg.sv
`default_nettype none
package aie_pkg;
    // data path and address widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int INSTR_W = 16;
    // opcode fields
    localparam logic [7:0] OPC_ADD_LIT = 8'h0F;
    localparam logic [7:0] OPC_AND_LIT = 8'h0B;
    localparam logic [5:0] OPC_ADD_REG = 6'h09;
    localparam logic [5:0] OPC_ADD_CARRY_REG = 6'h08;
    // field positions inside the instruction word
    localparam int DEST_BIT = 9;
    localparam int ACCESS_BIT = 8;
    // access bank split and indexed literal offset limit
    localparam logic [7:0] INDEX_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    // values after reset
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [15:0] INSTR_RESET = 16'h0000;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_ADD_LIT,
        OP_ADD_REG,
        OP_ADD_CARRY_REG,
        OP_AND_LIT
    } aie_op_type;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_DECODE,
        PH_READ,
        PH_PROC,
        PH_WRITE
    } aie_phase_type;

    typedef struct packed {
        logic n;
        logic overflow_flag;
        logic z;
        logic digit_carry_flag;
        logic c;
    } aie_flags_type;

    localparam aie_flags_type FLAGS_RESET = 5'h00;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic wr_en;
        logic [DATA_W-1:0] wr_data;
    } aie_mem_req_type;
endpackage
`default_nettype wire

// ===== test/tb_add_and_instruction_exec.sv
`default_nettype none
module tb_add_and_instruction_exec;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_in, rst_n_in, instr_valid_in, instr_ready_out, ext_set_en_in, done_out;
    logic [15:0] instr_in;
    logic [3:0] bank_select_register_in;
    logic [11:0] index_base_in;
    logic [7:0] mem_rd_data_in, w_out, exp_w;
    aie_pkg::aie_mem_req_type mem_req_out;
    aie_pkg::aie_flags_type flags_out, exp_fl;
    logic [7:0] mem [0:4095];
    int errors, n_tests, n;
    int cycles = 0;

    aie_exec DUT (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .instr_valid_in(instr_valid_in), .instr_in(instr_in),
        .instr_ready_out(instr_ready_out), .ext_set_en_in(ext_set_en_in),
        .bank_select_register_in(bank_select_register_in), .index_base_in(index_base_in),
        .mem_rd_data_in(mem_rd_data_in), .mem_req_out(mem_req_out),
        .w_out(w_out), .flags_out(flags_out), .done_out(done_out)
    );

    // data memory answers the registered address at once
    assign mem_rd_data_in = mem[mem_req_out.addr];

    // memory write port, only on the write-phase pulse
    always @(posedge sys_clk_in) begin
        if (mem_req_out.wr_en === 1'b1) mem[mem_req_out.addr] <= mem_req_out.wr_data;
    end

    // 50 ns clock
    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    // hang guard, far above the roughly 150 cycles the run needs
    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors = errors + 1;
            print_verdict();
        end
    end

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flags(input aie_pkg::aie_flags_type got, input aie_pkg::aie_flags_type exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t flags got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // hold reset six edges, then the model restarts from the reset values
    task automatic do_reset();
        @(posedge sys_clk_in);
        rst_n_in <= 1'b0;
        repeat (6) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        @(negedge sys_clk_in);
        chk_val({8'h00, w_out}, {8'h00, aie_pkg::W_RESET});
        chk_flags(flags_out, aie_pkg::FLAGS_RESET);
        chk_val({13'h0000, instr_ready_out, done_out, mem_req_out.wr_en}, 16'h0004);
        exp_w = aie_pkg::W_RESET;
        exp_fl = aie_pkg::FLAGS_RESET;
    endtask

    task automatic poke(input logic [11:0] a, input logic [7:0] v);
        @(posedge sys_clk_in);
        mem[a] <= v;
        // let the write land before the model reads memory
        @(negedge sys_clk_in);
    endtask

    task automatic setup(input logic ext, input logic [3:0] bank, input logic [11:0] base);
        @(posedge sys_clk_in);
        ext_set_en_in <= ext;
        bank_select_register_in <= bank;
        index_base_in <= base;
        // model reads these at once, so wait for the new values
        @(negedge sys_clk_in);
    endtask

    // one word through all four phases, judged against the bench's own model
    task automatic run(input logic [15:0] ins);
        logic [7:0] k, opnd;
        logic [11:0] addr;
        logic [8:0] sum;
        logic [4:0] lo;
        logic cin, is_reg, wr;
        k = ins[7:0];
        is_reg = ins[15:10] == aie_pkg::OPC_ADD_REG || ins[15:10] == aie_pkg::OPC_ADD_CARRY_REG;
        cin = (ins[15:10] == aie_pkg::OPC_ADD_CARRY_REG) ? exp_fl.c : 1'b0;
        if (ins[aie_pkg::ACCESS_BIT]) addr = {bank_select_register_in, k};
        else if (ext_set_en_in && k <= aie_pkg::INDEX_LIMIT) addr = index_base_in + {4'h0, k};
        else if (k < aie_pkg::ACCESS_SPLIT) addr = {aie_pkg::ACCESS_LOW_BANK, k};
        else addr = {aie_pkg::ACCESS_HIGH_BANK, k};
        opnd = is_reg ? mem[addr] : k;
        sum = exp_w + opnd + cin;
        lo = exp_w[3:0] + opnd[3:0] + cin;
        wr = is_reg && ins[aie_pkg::DEST_BIT];
        @(posedge sys_clk_in);
        instr_valid_in <= 1'b1;
        instr_in <= ins;
        @(negedge sys_clk_in);
        for (n = 0; n < 10 && instr_ready_out !== 1'b1; n++) @(negedge sys_clk_in);
        @(posedge sys_clk_in);
        instr_valid_in <= 1'b0;
        for (n = 1; n < 9; n++) begin
            @(negedge sys_clk_in);
            if (done_out === 1'b1) break;
        end
        chk_val(16'(n), 16'h0004);
        if (ins[15:8] == aie_pkg::OPC_AND_LIT) begin
            exp_w = exp_w & k;
            exp_fl.n = exp_w[7];
            exp_fl.z = exp_w == 8'h00;
        end else if (is_reg || ins[15:8] == aie_pkg::OPC_ADD_LIT) begin
            exp_fl = '{n: sum[7], overflow_flag: exp_w[7] == opnd[7] && sum[7] != exp_w[7],
                       z: sum[7:0] == 8'h00, digit_carry_flag: lo[4], c: sum[8]};
            if (!wr) exp_w = sum[7:0];
        end
        chk_val({8'h00, w_out}, {8'h00, exp_w});
        chk_flags(flags_out, exp_fl);
        chk_val({7'h00, mem_req_out.wr_en, wr ? mem_req_out.wr_data : 8'h00},
                {7'h00, wr, wr ? sum[7:0] : 8'h00});
        if (is_reg) chk_val({4'h0, mem_req_out.addr}, {4'h0, addr});
    endtask

    // literal adds across overflow, carry, zero and nibble carry
    task automatic t_add_lit();
        logic [7:0] lits [6] = '{8'h10, 8'h15, 8'h5B, 8'h80, 8'h0F, 8'h01};
        foreach (lits[i]) run({aie_pkg::OPC_ADD_LIT, lits[i]});
    endtask

    // carry and nibble carry set before the mask must survive it
    task automatic t_and_lit();
        run({aie_pkg::OPC_AND_LIT, 8'h00});
        run({aie_pkg::OPC_ADD_LIT, 8'hA3});
        run({aie_pkg::OPC_AND_LIT, 8'h5F});
        run({aie_pkg::OPC_ADD_LIT, 8'hFF});
        run({aie_pkg::OPC_AND_LIT, 8'h80});
    endtask

    // both destinations, high and low part of the access bank, banked access
    task automatic t_add_reg();
        poke(12'hF80, 8'hC2);
        poke(12'h533, 8'h40);
        setup(1'b0, 4'h5, 12'h000);
        run({aie_pkg::OPC_ADD_LIT, 8'h17});
        run(16'h2480);
        run(16'h2733);
        run(16'h2410);
        @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        chk_val({8'h00, mem[12'hF80]}, 16'h00C2);
        chk_val({8'h00, mem[12'h533]}, 16'h0019);
    endtask

    // carry in from the flag, then stored back to memory
    task automatic t_carry();
        poke(12'h520, 8'h02);
        run({aie_pkg::OPC_AND_LIT, 8'h00});
        run({aie_pkg::OPC_ADD_LIT, 8'hFF});
        run({aie_pkg::OPC_ADD_LIT, 8'h4E});
        run(16'h2120);
        run(16'h2320);
        @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        chk_val({8'h00, mem[12'h520]}, 16'h0052);
    endtask

    // indexed mode at the limit and one past it
    task automatic t_indexed();
        poke(12'h35F, 8'h01);
        setup(1'b1, 4'h5, 12'h300);
        run(16'h245F);
        run(16'h2460);
        run(16'h2760);
        setup(1'b0, 4'h5, 12'h000);
    endtask

    // second word waits exactly through three busy phases, then a mid-run reset
    task automatic t_b2b();
        @(posedge sys_clk_in);
        instr_valid_in <= 1'b1;
        instr_in <= {aie_pkg::OPC_ADD_LIT, 8'h01};
        @(negedge sys_clk_in);
        @(posedge sys_clk_in);
        instr_in <= {aie_pkg::OPC_ADD_LIT, 8'h02};
        for (n = 1; n < 9; n++) begin
            @(negedge sys_clk_in);
            if (instr_ready_out === 1'b1) break;
        end
        chk_val(16'(n), 16'h0004);
        chk_val({8'h00, w_out}, {8'h00, exp_w + 8'h01});
        @(posedge sys_clk_in);
        instr_valid_in <= 1'b0;
        repeat (4) @(negedge sys_clk_in);
        chk_val({7'h00, done_out, w_out}, {8'h01, exp_w + 8'h03});
        do_reset();
    endtask

    // stimulus sequence
    initial begin
        rst_n_in = 1'b0;
        instr_valid_in = 1'b0;
        instr_in = 16'h0000;
        ext_set_en_in = 1'b0;
        bank_select_register_in = 4'h0;
        index_base_in = 12'h000;
        errors = 0;
        n_tests = 0;
        foreach (mem[i]) mem[i] = 8'h00;
        do_reset();
        t_add_lit();
        t_and_lit();
        t_add_reg();
        t_carry();
        t_indexed();
        t_b2b();
        run(16'h0000);
        print_verdict();
    end
endmodule // tb_add_and_instruction_exec
`default_nettype wire
